// ===== src/aluex_core.sv
// Summary of operation
// - Add register, optional carry; ZCNVH; 1 cycle
// - Word add immediate on pair; ZCNVS; 2 cycles
// - Subtract register, optional borrow; ZCNVH; 1 cycle
// - Subtract constant, write back; ZCNVH; 1 cycle
// - Subtract constant and carry; ZCNVH; 1 cycle
// - Word subtract immediate on pair; ZCNVS; 2 cycles
// - AND constant; only ZNV change; 1 cycle
// - OR constant; only ZNV change; 1 cycle
// - Set bits OR mask, clear bits AND inverse
// - Test: value kept, ZNV from it
// - Indirect jump loads pointer, 2 cycles
// - Compare-skip-equal skips next; 1/2/3 cycles
// - Skip when register bit clear; 1/2/3 cycles
// - Skip when register bit set; 1/2/3 cycles
// - Skip when I/O bit clear; 1/2/3 cycles
// - Compare immediate, no write back; ZNVCH
`timescale 1ns/100ps
`default_nettype none

module aluex_core
  import aluex_pkg::*;
(
  input  wire logic        clk_sys_i,        // Core clock
  input  wire logic        rst_b_i,          // Async reset, low
  input  wire logic        start_i,          // Issue pulse
  input  wire aluex_op_t   op_i,             // Operation code
  input  wire logic [7:0]  rd_i,             // Destination value
  input  wire logic [7:0]  rdh_i,            // Pair high byte
  input  wire logic [7:0]  source_register_i,// Source value
  input  wire logic [15:0] k_i,              // Constant or target
  input  wire logic [2:0]  bit_sel_i,        // Bit to test
  input  wire logic [7:0]  io_val_i,         // I/O register value
  input  wire logic [15:0] pc_i,             // Current counter
  input  wire logic [15:0] zptr_i,           // Indirect pointer
  input  wire logic        next_two_word_i,  // Next is two words
  input  wire logic [15:0] stack_data_i,     // Top of stack
  input  wire logic [1:0]  bus_addr_i,       // Register address
  input  wire logic [7:0]  bus_wdata_i,      // Write data
  input  wire logic        bus_we_i,         // Write strobe
  input  wire logic        bus_re_i,         // Read strobe
  output logic [7:0]       bus_rdata_o,      // Read data
  output logic             busy_o,           // Multi-cycle op
  output logic             done_o,           // Completion pulse
  output logic [7:0]       result_o,         // Result byte
  output logic [7:0]       result_hi_o,      // Pair high result
  output logic             wr_rd_o,          // Write result
  output logic             wr_word_o,        // Write pair
  output logic [15:0]      pc_o,             // New counter
  output logic             pc_load_o,        // Load counter
  output logic             push_o,           // Push return
  output logic [15:0]      push_data_o,      // Return address
  output logic             pop_o,            // Pop return
  output logic [7:0]       sreg_o            // Status flags
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    aluex_state_t state;     // Sequencer
    logic [1:0]   cnt;       // Cycles left
    logic [7:0]   ctrl;      // Control reg
    logic [7:0]   sreg;      // Visible flags
    logic [7:0]   sreg_new;  // Pending flags
    logic [7:0]   res;       // Result
    logic [7:0]   res_hi;    // Pair high
    logic [15:0]  pc;        // Target
    logic [15:0]  push_data; // Return address
    logic         wr;        // Byte write pending
    logic         wword;     // Pair write pending
    logic         pcl;       // Counter load pending
    logic         push;      // Push pending
    logic         pop;       // Pop pending
    logic         done;      // Completion
    logic [2:0]   last_cyc;  // Last cycle count
    logic [7:0]   rdata;     // Bus read data
  } aluex_regs_t;

  aluex_regs_t q;       // Registered state
  aluex_regs_t next_q;  // Next state

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Byte add: {H, V, C, result}
  function automatic logic [10:0] f_add8(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       ci
  );
    logic [7:0] r;
    r = a + b + {7'h00, ci};
    f_add8 = {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
              (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]),
              (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]),
              r};
  endfunction

  // Byte subtract: {H, V, C, result}
  function automatic logic [10:0] f_sub8(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       ci
  );
    logic [7:0] r;
    r = a - b - {7'h00, ci};
    f_sub8 = {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
              (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
              (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]),
              r};
  endfunction

  // Apply an arithmetic outcome to Z, C, N, V, H
  // Chained forms keep zero only if it was already set,
  // so multi-byte compares test the whole width.
  function automatic logic [7:0] f_arith(
    input logic [7:0]  s,
    input logic [10:0] x,
    input logic        chain
  );
    logic [7:0] t;
    t        = s;
    t[FLG_Z] = (x[7:0] == 8'h00) & (~chain | s[FLG_Z]);
    t[FLG_C] = x[8];
    t[FLG_N] = x[7];
    t[FLG_V] = x[9];
    t[FLG_H] = x[10];
    f_arith  = t;
  endfunction

  // Update Z, N and V only; carry and half carry kept
  function automatic logic [7:0] f_znv(
    input logic [7:0] s,
    input logic [7:0] r,
    input logic       v
  );
    logic [7:0] t;
    t        = s;
    t[FLG_Z] = (r == 8'h00);
    t[FLG_N] = r[7];
    t[FLG_V] = v;
    f_znv    = t;
  endfunction

  // ****************************************************************
  // Operand selection and shared arithmetic
  // ****************************************************************
  logic [7:0]  opb;    // Second operand
  logic        cin;    // Carry into add/sub
  logic [10:0] add_x;  // Add outcome
  logic [10:0] sub_x;  // Subtract outcome
  logic [15:0] wsrc;   // Register pair
  logic [15:0] wres;   // Pair result
  logic        wv;     // Pair overflow
  logic        wc;     // Pair carry
  logic        skip;   // Skip condition
  logic [15:0] skip_pc;// Counter after skip test
  logic        bitval; // Selected register bit

  // Pick constant or register, and carry-in, per operation
  always_comb begin
    unique case (op_i)
      OP_SUB_IMMEDIATE, OP_SUB_BORROW_IMMEDIATE, OP_MASK_IMMEDIATE,
      OP_MERGE_IMMEDIATE, OP_SET_BITS_IMMEDIATE, OP_COMPARE_IMMEDIATE: begin
        opb = k_i[7:0];
      end
      OP_CLEAR_BITS_IMMEDIATE: begin
        opb = 8'hFF - k_i[7:0];
      end
      default: begin
        opb = source_register_i;
      end
    endcase
    cin = q.sreg[FLG_C] & ((op_i == OP_ADD_CARRY) |
                           (op_i == OP_SUB_WITH_BORROW) |
                           (op_i == OP_SUB_BORROW_IMMEDIATE) |
                           (op_i == OP_COMPARE_WITH_BORROW));
  end

  assign add_x = f_add8(rd_i, opb, cin);
  assign sub_x = f_sub8(rd_i, opb, cin);
  assign wsrc  = {rdh_i, rd_i};
  assign bitval = source_register_i[bit_sel_i];

  // Word arithmetic: constant is six bits wide
  always_comb begin
    if (op_i == OP_WORD_SUB_IMMEDIATE) begin
      wres = wsrc - {10'h000, k_i[5:0]};
      wv   = wsrc[15] & ~wres[15];
      wc   = wres[15] & ~wsrc[15];
    end else begin
      wres = wsrc + {10'h000, k_i[5:0]};
      wv   = ~wsrc[15] & wres[15];
      wc   = ~wres[15] & wsrc[15];
    end
  end

  // Skip condition for the compare and bit-test group
  always_comb begin
    unique case (op_i)
      OP_COMPARE_SKIP_EQUAL: skip = (rd_i == source_register_i);
      OP_SKIP_REG_BIT_CLEAR: skip = ~bitval;
      OP_SKIP_REG_BIT_SET:   skip = bitval;
      OP_SKIP_IO_BIT_CLEAR:  skip = ~io_val_i[bit_sel_i];
      default:               skip = 1'b0;
    endcase
    // Skipping a two-word instruction costs one extra cycle
    skip_pc = pc_i + (skip ? (next_two_word_i ? 16'h0003 : 16'h0002)
                           : 16'h0001);
  end

  // ****************************************************************
  // Sequencer and register port
  // ****************************************************************
  logic [2:0] cyc; // Cycles of the issued operation

  always_comb begin
    next_q       = q;
    next_q.done  = 1'b0;
    next_q.rdata = 8'h00;
    cyc          = CYC_1;
    // Read data stands only in the cycle after the strobe
    if (bus_re_i) begin
      unique case (bus_addr_i)
        REG_CTRL:   next_q.rdata = q.ctrl;
        REG_SREG:   next_q.rdata = q.sreg;
        REG_STATUS: next_q.rdata = {3'h0, q.last_cyc, 1'b0,
                                    q.state == ST_EXEC};
        REG_RESULT: next_q.rdata = q.res;
      endcase
    end
    // Software writes; a flag update from an operation wins below
    if (bus_we_i) begin
      if (bus_addr_i == REG_CTRL) begin
        next_q.ctrl = bus_wdata_i;
      end
      if (bus_addr_i == REG_SREG) begin
        next_q.sreg = bus_wdata_i;
      end
    end
    unique case (q.state)
      ST_IDLE: begin
        // Issue is ignored while execution is disabled
        if (start_i && q.ctrl[CTRL_EN_BIT]) begin
          next_q.sreg_new = next_q.sreg;
          next_q.wr       = 1'b0;
          next_q.wword    = 1'b0;
          next_q.pcl      = 1'b0;
          next_q.push     = 1'b0;
          next_q.pop      = 1'b0;
          next_q.res      = rd_i;
          next_q.pc       = pc_i + 16'h0001;
          unique case (op_i)
            OP_ADD, OP_ADD_CARRY: begin
              next_q.res      = add_x[7:0];
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_arith(next_q.sreg, add_x, 1'b0);
            end
            OP_SUB, OP_SUB_WITH_BORROW: begin
              next_q.res      = sub_x[7:0];
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_arith(next_q.sreg, sub_x,
                                        op_i == OP_SUB_WITH_BORROW);
            end
            OP_SUB_IMMEDIATE: begin
              next_q.res      = sub_x[7:0];
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_arith(next_q.sreg, sub_x, 1'b0);
            end
            OP_SUB_BORROW_IMMEDIATE: begin
              next_q.res      = sub_x[7:0];
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_arith(next_q.sreg, sub_x, 1'b1);
            end
            OP_COMPARE, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE: begin
              // Difference only sets flags; nothing is written back
              next_q.sreg_new = f_arith(next_q.sreg, sub_x,
                                        op_i == OP_COMPARE_WITH_BORROW);
            end
            OP_WORD_ADD_IMMEDIATE, OP_WORD_SUB_IMMEDIATE: begin
              cyc                     = CYC_2;
              next_q.res              = wres[7:0];
              next_q.res_hi           = wres[15:8];
              next_q.wword            = 1'b1;
              next_q.sreg_new[FLG_Z]  = (wres == 16'h0000);
              next_q.sreg_new[FLG_C]  = wc;
              next_q.sreg_new[FLG_N]  = wres[15];
              next_q.sreg_new[FLG_V]  = wv;
              next_q.sreg_new[FLG_S]  = wres[15] ^ wv;
            end
            OP_AND, OP_MASK_IMMEDIATE, OP_CLEAR_BITS_IMMEDIATE: begin
              next_q.res      = rd_i & opb;
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_znv(next_q.sreg, rd_i & opb, 1'b0);
            end
            OP_OR, OP_MERGE_IMMEDIATE, OP_SET_BITS_IMMEDIATE: begin
              next_q.res      = rd_i | opb;
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_znv(next_q.sreg, rd_i | opb, 1'b0);
            end
            OP_EXCLUSIVE_MERGE: begin
              next_q.res      = rd_i ^ opb;
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_znv(next_q.sreg, rd_i ^ opb, 1'b0);
            end
            OP_TEST_ZERO_MINUS: begin
              // Value unchanged, so no write strobe
              next_q.sreg_new = f_znv(next_q.sreg, rd_i, 1'b0);
            end
            OP_ONES_COMPLEMENT: begin
              next_q.res             = 8'hFF - rd_i;
              next_q.wr              = 1'b1;
              next_q.sreg_new        = f_znv(next_q.sreg, 8'hFF - rd_i, 1'b0);
              next_q.sreg_new[FLG_C] = 1'b1;
            end
            OP_TWOS_COMPLEMENT: begin
              next_q.res             = 8'h00 - rd_i;
              next_q.wr              = 1'b1;
              next_q.sreg_new        = f_arith(next_q.sreg,
                                               f_sub8(8'h00, rd_i, 1'b0),
                                               1'b0);
            end
            OP_INC: begin
              next_q.res      = rd_i + 8'h01;
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_znv(next_q.sreg, rd_i + 8'h01,
                                      rd_i == 8'h7F);
            end
            OP_DEC: begin
              next_q.res      = rd_i - 8'h01;
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_znv(next_q.sreg, rd_i - 8'h01,
                                      rd_i == 8'h80);
            end
            OP_ZERO_REGISTER: begin
              next_q.res      = rd_i ^ rd_i;
              next_q.wr       = 1'b1;
              next_q.sreg_new = f_znv(next_q.sreg, 8'h00, 1'b0);
            end
            OP_FILL_REGISTER_ONES: begin
              next_q.res = 8'hFF;
              next_q.wr  = 1'b1;
            end
            OP_RELATIVE_JUMP: begin
              cyc        = CYC_2;
              next_q.pc  = pc_i + {{4{k_i[11]}}, k_i[11:0]} + 16'h0001;
              next_q.pcl = 1'b1;
            end
            OP_INDIRECT_JUMP: begin
              cyc        = CYC_2;
              next_q.pc  = zptr_i;
              next_q.pcl = 1'b1;
            end
            OP_DIRECT_JUMP: begin
              cyc        = CYC_3;
              next_q.pc  = k_i;
              next_q.pcl = 1'b1;
            end
            OP_RELATIVE_CALL, OP_INDIRECT_CALL: begin
              cyc              = CYC_3;
              next_q.pc        = (op_i == OP_INDIRECT_CALL) ? zptr_i :
                                 pc_i + {{4{k_i[11]}}, k_i[11:0]} + 16'h0001;
              next_q.pcl       = 1'b1;
              next_q.push      = 1'b1;
              next_q.push_data = pc_i + 16'h0001;
            end
            OP_DIRECT_CALL: begin
              // Two-word instruction: return past its second word
              cyc              = CYC_4;
              next_q.pc        = k_i;
              next_q.pcl       = 1'b1;
              next_q.push      = 1'b1;
              next_q.push_data = pc_i + 16'h0002;
            end
            OP_SUB_RETURN, OP_INTERRUPT_RETURN: begin
              cyc        = CYC_4;
              next_q.pc  = stack_data_i;
              next_q.pcl = 1'b1;
              next_q.pop = 1'b1;
              if (op_i == OP_INTERRUPT_RETURN) begin
                next_q.sreg_new[FLG_I] = 1'b1;
              end
            end
            OP_COMPARE_SKIP_EQUAL, OP_SKIP_REG_BIT_CLEAR,
            OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR: begin
              // One cycle, plus one or two when skipping
              cyc        = (!skip) ? CYC_1 :
                           (next_two_word_i ? CYC_3 : CYC_2);
              next_q.pc  = skip_pc;
              next_q.pcl = 1'b1;
            end
            default: begin
              next_q.res = rd_i;
            end
          endcase
          next_q.last_cyc = cyc;
          if (cyc == CYC_1) begin
            next_q.done = 1'b1;
            next_q.sreg = next_q.sreg_new;
          end else begin
            next_q.state = ST_EXEC;
            next_q.cnt   = 2'(cyc - CYC_2);
          end
        end
      end
      ST_EXEC: begin
        // Write strobes and flags are published on the last cycle; result and target register at issue
        if (q.cnt == 2'h0) begin
          next_q.done  = 1'b1;
          next_q.sreg  = q.sreg_new;
          next_q.state = ST_IDLE;
        end else begin
          next_q.cnt = q.cnt - 2'h1;
        end
      end
      default: begin
        next_q.state = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q          <= '0;
      q.state    <= ST_IDLE;
      q.ctrl     <= CTRL_RST;
      q.sreg     <= SREG_RST;
      q.sreg_new <= SREG_RST;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Strobes are gated by the completion pulse so they last one cycle
  assign bus_rdata_o = q.rdata;
  assign busy_o      = (q.state == ST_EXEC);
  assign done_o      = q.done;
  assign result_o    = q.res;
  assign result_hi_o = q.res_hi;
  assign wr_rd_o     = q.done & q.wr;
  assign wr_word_o   = q.done & q.wword;
  assign pc_o        = q.pc;
  assign pc_load_o   = q.done & q.pcl;
  assign push_o      = q.done & q.push;
  assign push_data_o = q.push_data;
  assign pop_o       = q.done & q.pop;
  assign sreg_o      = q.sreg;

endmodule

`default_nettype wire

// ===== include/aluex_pkg.sv
// ****************************************************************
// Shared constants for the ALU and branch executer
// ****************************************************************
package aluex_pkg;

  // Register port offsets
  localparam logic [1:0] REG_CTRL   = 2'h0;  // Enable control
  localparam logic [1:0] REG_SREG   = 2'h1;  // Status flags
  localparam logic [1:0] REG_STATUS = 2'h2;  // Busy and cycle count
  localparam logic [1:0] REG_RESULT = 2'h3;  // Last result byte

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h01;   // Execution enabled
  localparam logic [7:0] SREG_RST = 8'h00;   // All flags clear

  // Status flag positions
  localparam int unsigned FLG_C = 0;  // Carry
  localparam int unsigned FLG_Z = 1;  // Zero
  localparam int unsigned FLG_N = 2;  // Negative
  localparam int unsigned FLG_V = 3;  // Overflow
  localparam int unsigned FLG_S = 4;  // Sign
  localparam int unsigned FLG_H = 5;  // Half carry
  localparam int unsigned FLG_I = 7;  // Global interrupt enable

  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;  // Execution enable
  localparam int unsigned STS_BUSY    = 0;  // Busy in status

  // Cycle counts
  localparam logic [2:0] CYC_1 = 3'h1;  // Single cycle
  localparam logic [2:0] CYC_2 = 3'h2;  // Two cycles
  localparam logic [2:0] CYC_3 = 3'h3;  // Three cycles
  localparam logic [2:0] CYC_4 = 3'h4;  // Four cycles

  // Operation codes
  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_ADD_IMMEDIATE, OP_SUB,
    OP_SUB_IMMEDIATE, OP_SUB_WITH_BORROW, OP_SUB_BORROW_IMMEDIATE,
    OP_WORD_SUB_IMMEDIATE, OP_AND, OP_MASK_IMMEDIATE, OP_OR,
    OP_MERGE_IMMEDIATE, OP_EXCLUSIVE_MERGE, OP_ONES_COMPLEMENT,
    OP_TWOS_COMPLEMENT, OP_SET_BITS_IMMEDIATE, OP_CLEAR_BITS_IMMEDIATE,
    OP_INC, OP_DEC, OP_TEST_ZERO_MINUS, OP_ZERO_REGISTER,
    OP_FILL_REGISTER_ONES, OP_RELATIVE_JUMP, OP_INDIRECT_JUMP,
    OP_DIRECT_JUMP, OP_RELATIVE_CALL, OP_INDIRECT_CALL, OP_DIRECT_CALL,
    OP_SUB_RETURN, OP_INTERRUPT_RETURN, OP_COMPARE_SKIP_EQUAL,
    OP_COMPARE, OP_COMPARE_WITH_BORROW, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR
  } aluex_op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } aluex_state_t;

endpackage

// ===== sim/aluex_core_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Port checker for the ALU and branch executer
// ****************************************************************
module aluex_chk
  import aluex_pkg::*;
(
  input wire logic        clk_sys_i,   // Core clock
  input wire logic        rst_b_i,     // Async reset, low
  input wire logic        start_i,     // Issue pulse
  input wire aluex_op_t   op_i,        // Operation code
  input wire logic [7:0]  rd_i,        // Destination value
  input wire logic [15:0] k_i,         // Constant or target
  input wire logic [15:0] pc_i,        // Current counter
  input wire logic [15:0] zptr_i,      // Indirect pointer
  input wire logic [1:0]  bus_addr_i,  // Register address
  input wire logic [7:0]  bus_wdata_i, // Write data
  input wire logic        bus_we_i,    // Write strobe
  input wire logic        bus_re_i,    // Read strobe
  input wire logic [7:0]  bus_rdata_o, // Read data
  input wire logic        busy_o,      // Multi-cycle op
  input wire logic        done_o,      // Completion pulse
  input wire logic [7:0]  result_o,    // Result byte
  input wire logic        wr_rd_o,     // Write result
  input wire logic        wr_word_o,   // Write pair
  input wire logic [15:0] pc_o,        // New counter
  input wire logic        pc_load_o,   // Load counter
  input wire logic        pop_o,       // Pop return
  input wire logic [7:0]  sreg_o       // Status flags
);
  logic en_q;  // Shadow of the enable bit, since the checker cannot see it
  logic take;  // An issue the block must accept
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) en_q <= CTRL_RST[CTRL_EN_BIT];
    else if (bus_we_i && bus_addr_i == REG_CTRL) en_q <= bus_wdata_i[CTRL_EN_BIT];
  end
  assign take = start_i && !busy_o && en_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  AST_STROBE_DONE: assert property ((wr_rd_o || wr_word_o || pc_load_o) |->
    done_o && $onehot({wr_rd_o, wr_word_o, pc_load_o}))
    else $error("strobe without done");
  AST_ADD_ONE: assert property (take && op_i == OP_ADD_CARRY |=> done_o && wr_rd_o)
    else $error("add not done in one cycle");
  AST_WORD_TWO: assert property (take && op_i == OP_WORD_ADD_IMMEDIATE |=>
    busy_o && !done_o ##1 done_o && wr_word_o && !busy_o)
    else $error("word add not two cycles");
  AST_KEEP_CH: assert property (take && op_i == OP_MASK_IMMEDIATE && !$past(start_i) && !bus_we_i |=>
    sreg_o[FLG_C] == $past(sreg_o[FLG_C]) && sreg_o[FLG_H] == $past(sreg_o[FLG_H]))
    else $error("mask changed carry or half carry");
  AST_TEST_NOWR: assert property (take && op_i == OP_TEST_ZERO_MINUS |=>
    done_o && !wr_rd_o && result_o == $past(rd_i))
    else $error("test wrote or changed value");
  AST_INDIRECT_JUMP: assert property (take && op_i == OP_INDIRECT_JUMP |=>
    !done_o ##1 done_o && pc_load_o && pc_o == $past(zptr_i, 2))
    else $error("indirect jump wrong");
  AST_RELATIVE_JUMP: assert property (take && op_i == OP_RELATIVE_JUMP |=> !done_o ##1 done_o &&
    pc_o == $past(pc_i, 2) + {{4{$past(k_i[11], 2)}}, $past(k_i[11:0], 2)} + 16'h0001)
    else $error("relative jump wrong");
  AST_INTERRUPT_RETURN: assert property (take && op_i == OP_INTERRUPT_RETURN |=>
    !done_o [*3] ##1 done_o && pop_o && sreg_o[FLG_I])
    else $error("interrupt return wrong");
  AST_REFUSE: assert property (start_i && !en_q && !busy_o && !$past(start_i) |=> !done_o)
    else $error("issue taken while disabled");
  AST_RD_IDLE: assert property (!bus_re_i |=> bus_rdata_o == 8'h00)
    else $error("read data outside read slot");
  cover property (take && op_i == OP_WORD_ADD_IMMEDIATE);
  cover property (take && op_i == OP_SKIP_REG_BIT_SET);
  cover property (take && op_i == OP_INTERRUPT_RETURN);
endmodule
bind aluex_core aluex_chk chk_u (.*);
`default_nettype wire

// ===== sim/alu_branch_instruction_exec_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module alu_branch_instruction_exec_tb_top;
  import aluex_pkg::*;
  logic clk_sys_i = 0, rst_b_i = 0, start_i = 0, nt = 0, we = 0, re = 0;
  aluex_op_t op = OP_ADD;
  logic [7:0] rd = 0, rdh = 0, rs = 0, io = 0, wd = 0, rdata, res, resh, sreg;
  logic [15:0] k = 0, pc = 0, z = 0, stk = 0, pco, pushd;
  logic [2:0] bs = 0;
  logic [1:0] ad = 0;
  logic busy, done, wr, ww, pcl, push, pop;
  int errors = 0, compares = 0, cyc = 0;
  aluex_core dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .start_i(start_i), .op_i(op), .rd_i(rd),
    .rdh_i(rdh), .source_register_i(rs), .k_i(k), .bit_sel_i(bs), .io_val_i(io), .pc_i(pc), .zptr_i(z),
    .next_two_word_i(nt), .stack_data_i(stk), .bus_addr_i(ad), .bus_wdata_i(wd), .bus_we_i(we),
    .bus_re_i(re), .bus_rdata_o(rdata), .busy_o(busy), .done_o(done), .result_o(res), .result_hi_o(resh),
    .wr_rd_o(wr), .wr_word_o(ww), .pc_o(pco), .pc_load_o(pcl), .push_o(push), .push_data_o(pushd),
    .pop_o(pop), .sreg_o(sreg));
  // ****************************************************************
  // Clock, reset and hang guard
  // ****************************************************************
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin  // Far beyond the few dozen cycles the run needs
      errors++;
      give_verdict;
    end
  end
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Register port: one-cycle strobes, read data in the following cycle only
  task automatic wr_reg(logic [1:0] a, logic [7:0] d);
    @(posedge clk_sys_i); ad <= a; wd <= d; we <= 1;
    @(posedge clk_sys_i); we <= 0;
  endtask
  task automatic rd_reg(logic [1:0] a, logic [7:0] e);
    @(posedge clk_sys_i); ad <= a; re <= 1;
    @(posedge clk_sys_i); re <= 0;
    #1 chk("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  // Issue one op and count cycles to done; 9 means no completion seen
  task automatic run(aluex_op_t o, logic [7:0] a, logic [7:0] b, logic [15:0] kk, int n);
    int c;
    @(posedge clk_sys_i); op <= o; rd <= a; rs <= b; k <= kk; start_i <= 1;
    @(posedge clk_sys_i); start_i <= 0;
    #1 c = 1;
    while (done !== 1'b1 && c < 9) begin
      @(posedge clk_sys_i);
      #1 c++;
    end
    chk("cycles", 16'(c), 16'(n));
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    rd_reg(REG_SREG, SREG_RST);
    rd_reg(REG_CTRL, CTRL_RST);
    wr_reg(REG_SREG, 8'h01);  // Carry set for the next add
    rd_reg(REG_SREG, 8'h01);
  endtask
  task automatic t_arith;
    run(OP_ADD_CARRY, 8'h7F, 8'h00, 16'h0000, 1);
    chk("add", {7'h00, wr, res}, 16'h0180);
    chk("sreg", {8'h00, sreg}, 16'h002C);
    rdh <= 8'hFF;  // Pair wraps to zero
    run(OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'h00, 16'h0001, 2);
    chk("pair", {resh, res}, 16'h0000);
    chk("sreg", {7'h00, ww, sreg}, 16'h0123);
    run(OP_MASK_IMMEDIATE, 8'h80, 8'h00, 16'h00F0, 1);
    chk("mask", {8'h00, res}, 16'h0080);
    chk("sreg", {8'h00, sreg}, 16'h0025);
    run(OP_TEST_ZERO_MINUS, 8'h00, 8'h00, 16'h0000, 1);
    chk("test", {7'h00, wr, sreg}, 16'h0023);
    run(OP_SUB_BORROW_IMMEDIATE, 8'h10, 8'h00, 16'h0001, 1);
    chk("subbi", {res, sreg}, 16'h0E20);
    run(OP_TWOS_COMPLEMENT, 8'h01, 8'h00, 16'h0000, 1);
    chk("twos", {res, sreg}, 16'hFF25);
    run(OP_COMPARE_IMMEDIATE, 8'h05, 8'h00, 16'h0005, 1);
    chk("cmpi", {7'h00, wr, sreg}, 16'h0002);
  endtask
  task automatic t_branch;
    pc <= 16'h0100;
    run(OP_RELATIVE_JUMP, 8'h00, 8'h00, 16'h0FFE, 2);
    chk("relative_jump", pco, 16'h00FF);
    z <= 16'hABCD;
    run(OP_INDIRECT_JUMP, 8'h00, 8'h00, 16'h0000, 2);
    chk("indirect_jump", pco, 16'hABCD);
    pc <= 16'h0200; nt <= 1; bs <= 3'h3;
    run(OP_SKIP_REG_BIT_SET, 8'h00, 8'h08, 16'h0000, 3);
    chk("skip", pco, 16'h0203);
    bs <= 3'h2;
    run(OP_SKIP_REG_BIT_SET, 8'h00, 8'h08, 16'h0000, 1);
    chk("noskip", pco, 16'h0201);
    chk("sreg", {8'h00, sreg}, 16'h0002);
    stk <= 16'h0456;
    run(OP_INTERRUPT_RETURN, 8'h00, 8'h00, 16'h0000, 4);
    chk("interrupt_return", pco, 16'h0456);
    chk("sreg", {7'h00, pop, sreg}, 16'h0182);
  endtask
  // Disabled block must ignore an issue
  task automatic t_refuse;
    wr_reg(REG_CTRL, 8'h00);
    run(OP_ADD, 8'h01, 8'h01, 16'h0000, 9);
    wr_reg(REG_CTRL, CTRL_RST);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_b_i <= 1;
    t_regs;
    t_arith;
    t_branch;
    t_refuse;
    give_verdict;
  end
endmodule
`default_nettype wire
